// File: inc/bscd_pkg.sv
// package: switch encodings, port bases and serial framing constants
package bscd_pkg;
   localparam int SW_WIDTH       = 8;             // switch bank width
   localparam int PIN_UMPROT     = 0;             // pin 1 position
   localparam int PIN_EEPLOAD    = 1;             // pin 2 position
   localparam int PIN_LANG       = 2;             // pin 3 position
   localparam int PIN_EXTFC      = 3;             // pin 4 position
   localparam int PIN_SERDEF     = 4;             // pin 5 position
   localparam int PIN_TERM       = 5;             // pin 6 position
   localparam int PIN_BASE_LO    = 6;             // pin 7 position
   localparam int PIN_BASE_HI    = 7;             // pin 8 position
   localparam logic [7:0]  SW_RESET   = 8'h00;   // all off before latch
   localparam logic [15:0] BASE_ONON  = 16'h0370; // pin8 on, pin7 on
   localparam logic [15:0] BASE_ONOFF = 16'h0380; // pin8 on, pin7 off
   localparam logic [15:0] BASE_OFFON = 16'h0390; // pin8 off, pin7 on
   localparam logic [15:0] BASE_OFFOFF= 16'h03A0; // pin8 off, pin7 off
   localparam logic [15:0] WIN_SPAN   = 16'h0005; // addresses in window
   localparam logic [3:0]  SER_START  = 4'h1;    // default start bits
   localparam logic [3:0]  SER_DATA   = 4'h7;    // default data bits
   localparam logic [3:0]  SER_STOP   = 4'h2;    // default stop bits
   localparam logic [1:0]  PAR_EVEN   = 2'h1;    // parity code: even
   localparam logic [15:0] SER_BAUD   = 16'h2580; // 9,600 bps default
   localparam logic [15:0] SER_WORD_RESET = 16'h0000; // stored word reset
   localparam logic [7:0]  FC_WIDTH_RESET = 8'h00;    // code reset value
   typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_RUN} bscd_state_type;
endpackage : bscd_pkg

// File: inc/bscd_cfg_if.sv
// interface: latched configuration between top and port map module
`timescale 1ns/1ps
`default_nettype none
interface bscd_cfg_if;
   logic [1:0] baseSel;   // pins 8,7 latched
   logic       valid;     // configuration latched
   logic [15:0] ioAddr;   // host address to check
   logic       hit;       // address falls in window
   logic [15:0] base;     // first window address
   modport ctl (output baseSel, output valid, output ioAddr,
                input hit, input base);
   modport map (input baseSel, input valid, input ioAddr,
                output hit, output base);
endinterface : bscd_cfg_if
`default_nettype wire

// File: core/bscd_port_map.sv
// module: host register window decode from latched base select
`timescale 1ns/1ps
`default_nettype none
module bscd_port_map (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic clkEn,
   bscd_cfg_if.map   cfg
);
   logic [15:0] baseSel_w;   // decoded base
   logic        inWin_w;     // address within five-word window
   logic [15:0] base_r;
   logic        hit_r;

   // base select: index is {pin8, pin7}
   assign baseSel_w = (cfg.baseSel == 2'b11) ? bscd_pkg::BASE_ONON :
                      (cfg.baseSel == 2'b10) ? bscd_pkg::BASE_ONOFF :
                      (cfg.baseSel == 2'b01) ? bscd_pkg::BASE_OFFON :
                                               bscd_pkg::BASE_OFFOFF; // RULE_09
   // window compare, span of five addresses
   assign inWin_w = cfg.valid && (cfg.ioAddr >= baseSel_w) &&
                    (cfg.ioAddr < baseSel_w + bscd_pkg::WIN_SPAN); // RULE_09

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         base_r <= bscd_pkg::BASE_OFFOFF;
         hit_r  <= 1'b0;
      end else if (clkEn) begin
         base_r <= baseSel_w;
         hit_r  <= inWin_w;
      end
   end
   assign cfg.base = base_r;
   assign cfg.hit  = hit_r;
endmodule : bscd_port_map
`default_nettype wire

// File: core/bscd_top.sv
// module: board strap configuration decoder top level
// Functional notes
// RULE_01: pin 1 on refuses peripheral program writes
// RULE_02: pin 2 on copies eeprom at startup
// RULE_03: pin 3 selects english or japanese messages
// RULE_04: pin 4 enables user extended function codes
// RULE_05: pin 5 forces default 7E2 9600 framing
// RULE_06: expansion board present routes serial there
// RULE_07: pin 6 selects extended terminal mode
// RULE_08: terminal mode maps keys or shows messages
// RULE_09: pins 8,7 pick five-address host window
// RULE_10: switches latched once after reset release
`timescale 1ns/1ps
`default_nettype none
module bscd_top (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        clkEn,        // freezes all state when low
   input  wire logic [7:0]  swPins,       // switch levels, 1 = on
   input  wire logic        expBoardPresent, // expansion board attached
   // peripheral program write request
   input  wire logic        progWrReq,
   // extended function code assignment request
   input  wire logic        fcAssignReq,
   input  wire logic [7:0]  fcAssignCode,
   // stored serial parameters from programming device
   input  wire logic [15:0] userSerBaud,
   input  wire logic [3:0]  userSerData,
   input  wire logic [3:0]  userSerStop,
   input  wire logic [1:0]  userSerParity,
   // terminal mode requests
   input  wire logic        termKeyMapSel,  // 1 keymap, 0 message display
   input  wire logic        keyPress,
   input  wire logic [4:0]  keyIndex,
   input  wire logic        msgValid,       // message instruction output
   input  wire logic [7:0]  msgChar,
   // host address probe
   input  wire logic [15:0] hostIoAddr,
   // outputs
   output logic             cfgValid,
   output logic             progWrAccept,
   output logic             progWrReject,
   output logic             eepCopyStart,
   output logic             langEnglish,
   output logic             fcAssignAccept,
   output logic             fcAssignReject,
   output logic [7:0]       fcActive,       // code in force, 0 = default
   output logic [15:0]      serBaud,
   output logic [3:0]       serStartBits,
   output logic [3:0]       serDataBits,
   output logic [3:0]       serStopBits,
   output logic [1:0]       serParity,
   output logic             serUseExpPort,
   output logic             serOwnPortEn,
   output logic             termMode,
   output logic [31:0]      auxKeyBits,
   output logic             consoleMsgValid,
   output logic [7:0]       consoleMsgChar,
   output logic [15:0]      ioBase,
   output logic             ioHit
);
   bscd_cfg_if cfgBus ();

   bscd_pkg::bscd_state_type state_r;  // latch sequencer
   bscd_pkg::bscd_state_type state_nxt;
   logic [7:0]  sw_r;                   // latched switch bank
   logic        protOn_w;               // pin 1 latched
   logic        eepOn_w;
   logic        extFcOn_w;
   logic        serDefOn_w;
   logic        termOn_w;
   logic        progAcc_w;
   logic        fcAcc_w;
   logic [31:0] keyMask_w;

   ////////////////////////////////////////////////////////////////////////
   // decode of latched switches
   assign protOn_w   = sw_r[bscd_pkg::PIN_UMPROT];
   assign eepOn_w    = sw_r[bscd_pkg::PIN_EEPLOAD];
   assign extFcOn_w  = sw_r[bscd_pkg::PIN_EXTFC];
   assign serDefOn_w = sw_r[bscd_pkg::PIN_SERDEF];
   assign termOn_w   = sw_r[bscd_pkg::PIN_TERM];
   // writes only accepted once config latched and unprotected
   assign progAcc_w  = progWrReq && cfgValid && !protOn_w; // RULE_01
   assign fcAcc_w    = fcAssignReq && cfgValid && extFcOn_w; // RULE_04
   assign keyMask_w  = 32'h0000_0001 << keyIndex;

   // sequencer: idle one cycle after release, latch, then run forever
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bscd_pkg::ST_IDLE:  state_nxt = bscd_pkg::ST_LATCH;
         bscd_pkg::ST_LATCH: state_nxt = bscd_pkg::ST_RUN;
         default:            state_nxt = bscd_pkg::ST_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state and switch latch
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= bscd_pkg::ST_IDLE;
         sw_r    <= bscd_pkg::SW_RESET;
      end else if (clkEn) begin
         state_r <= state_nxt;
         // single capture; later switch moves are ignored
         if (state_r == bscd_pkg::ST_LATCH) begin
            sw_r <= swPins; // RULE_10
         end
      end
   end

   // configuration flag and one-shot eeprom copy
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgValid     <= 1'b0;
         eepCopyStart <= 1'b0;
      end else if (clkEn) begin
         cfgValid     <= (state_r != bscd_pkg::ST_IDLE);
         eepCopyStart <= (state_r == bscd_pkg::ST_LATCH) &&
                         swPins[bscd_pkg::PIN_EEPLOAD]; // RULE_02
      end
   end

   // program write and function code arbitration
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         progWrAccept   <= 1'b0;
         progWrReject   <= 1'b0;
         fcAssignAccept <= 1'b0;
         fcAssignReject <= 1'b0;
         fcActive       <= bscd_pkg::FC_WIDTH_RESET;
      end else if (clkEn) begin
         progWrAccept   <= progAcc_w; // RULE_01
         progWrReject   <= progWrReq && !progAcc_w; // RULE_01
         fcAssignAccept <= fcAcc_w; // RULE_04
         fcAssignReject <= fcAssignReq && !fcAcc_w; // RULE_04
         // switch off forces default codes
         if (!extFcOn_w) begin
            fcActive <= bscd_pkg::FC_WIDTH_RESET; // RULE_04
         end else if (fcAcc_w) begin
            fcActive <= fcAssignCode;
         end
      end
   end

   // serial framing and port routing
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         serBaud       <= bscd_pkg::SER_WORD_RESET;
         serStartBits  <= bscd_pkg::SER_START;
         serDataBits   <= 4'h0;
         serStopBits   <= 4'h0;
         serParity     <= 2'h0;
         serUseExpPort <= 1'b0;
         serOwnPortEn  <= 1'b0;
         langEnglish   <= 1'b0;
         termMode      <= 1'b0;
      end else if (clkEn) begin
         if (serDefOn_w) begin
            serBaud     <= bscd_pkg::SER_BAUD; // RULE_05
            serDataBits <= bscd_pkg::SER_DATA;
            serStopBits <= bscd_pkg::SER_STOP;
            serParity   <= bscd_pkg::PAR_EVEN;
         end else begin
            serBaud     <= userSerBaud; // RULE_05
            serDataBits <= userSerData;
            serStopBits <= userSerStop;
            serParity   <= userSerParity;
         end
         serStartBits  <= bscd_pkg::SER_START;
         // only one port may drive the line at a time
         serUseExpPort <= cfgValid && expBoardPresent; // RULE_06
         serOwnPortEn  <= cfgValid && !expBoardPresent; // RULE_06
         langEnglish   <= sw_r[bscd_pkg::PIN_LANG]; // RULE_03
         termMode      <= termOn_w; // RULE_07
      end
   end

   // extended terminal: key mapping or message pass-through
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         auxKeyBits      <= 32'h0000_0000;
         consoleMsgValid <= 1'b0;
         consoleMsgChar  <= 8'h00;
      end else if (clkEn) begin
         if (termOn_w && termKeyMapSel && keyPress) begin
            auxKeyBits <= auxKeyBits | keyMask_w; // RULE_08
         end
         consoleMsgValid <= termOn_w && !termKeyMapSel && msgValid; // RULE_08
         if (termOn_w && !termKeyMapSel && msgValid) begin
            consoleMsgChar <= msgChar;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host window decode
   assign cfgBus.baseSel = {sw_r[bscd_pkg::PIN_BASE_HI],
                            sw_r[bscd_pkg::PIN_BASE_LO]};
   assign cfgBus.valid   = cfgValid;
   assign cfgBus.ioAddr  = hostIoAddr;

   bscd_port_map uMap (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clkEn   (clkEn),
      .cfg     (cfgBus.map)
   );

   // map outputs re-registered so top outputs come from flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ioBase <= bscd_pkg::BASE_OFFOFF;
         ioHit  <= 1'b0;
      end else if (clkEn) begin
         ioBase <= cfgBus.base; // RULE_09
         ioHit  <= cfgBus.hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   property p_prot;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn && progWrReq && cfgValid && sw_r[0] |=> !progWrAccept;
   endproperty
   a_prot: assert property (p_prot) else $error("protected write taken"); // RULE_01
   property p_eep;
      @(posedge sys_clk) disable iff (!arst_n)
      eepCopyStart |-> $past(swPins[1]);
   endproperty
   a_eep: assert property (p_eep) else $error("eeprom copy without pin"); // RULE_02
   property p_lang;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn |=> langEnglish == $past(sw_r[2]);
   endproperty
   a_lang: assert property (p_lang) else $error("language mismatch"); // RULE_03
   property p_fc;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn && fcAssignReq && !sw_r[3] |=> fcAssignReject && fcActive == 8'h00;
   endproperty
   a_fc: assert property (p_fc) else $error("code assign not refused"); // RULE_04
   property p_ser;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn && sw_r[4] |=> serBaud == 16'h2580 && serDataBits == 4'h7
         && serStopBits == 4'h2 && serParity == 2'h1;
   endproperty
   a_ser: assert property (p_ser) else $error("default framing wrong"); // RULE_05
   property p_route;
      @(posedge sys_clk) disable iff (!arst_n)
      !(serUseExpPort && serOwnPortEn);
   endproperty
   a_route: assert property (p_route) else $error("both ports enabled"); // RULE_06
   property p_term;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn |=> termMode == $past(sw_r[5]);
   endproperty
   a_term: assert property (p_term) else $error("terminal mode wrong"); // RULE_07
   property p_key;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn && sw_r[5] && termKeyMapSel && keyPress
         |=> auxKeyBits[$past(keyIndex)];
   endproperty
   a_key: assert property (p_key) else $error("key bit not set"); // RULE_08
   property p_base;
      @(posedge sys_clk) disable iff (!arst_n)
      clkEn && state_r == bscd_pkg::ST_RUN ##1 clkEn [*2]
         |=> ioBase == ((sw_r[7:6] == 2'b11) ? 16'h0370 :
                        (sw_r[7:6] == 2'b10) ? 16'h0380 :
                        (sw_r[7:6] == 2'b01) ? 16'h0390 : 16'h03A0);
   endproperty
   a_base: assert property (p_base) else $error("base address wrong"); // RULE_09
   property p_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      state_r == bscd_pkg::ST_RUN |=> $stable(sw_r);
   endproperty
   a_hold: assert property (p_hold) else $error("switches relatched"); // RULE_10
   c_eep:  cover property (@(posedge sys_clk) eepCopyStart);
   c_rej:  cover property (@(posedge sys_clk) progWrReject);
   c_hit:  cover property (@(posedge sys_clk) ioHit);
   c_msg:  cover property (@(posedge sys_clk) consoleMsgValid);
endmodule : bscd_top
`default_nettype wire

// File: verif/bscd_console_model.sv
// handheld console and programming device model
`timescale 1ns/1ps
`default_nettype none
module bscd_console_model (
   input  wire logic sys_clk,
   output logic      progWrReq,
   output logic      fcAssignReq,
   output logic [7:0] fcAssignCode,
   output logic      keyPress,
   output logic [4:0] keyIndex,
   output logic      msgValid,
   output logic [7:0] msgChar
);
   // all strobes idle at time zero
   initial begin
      {progWrReq, fcAssignReq, keyPress, msgValid} = 4'h0;
      fcAssignCode = 8'h00;
      keyIndex = 5'h00;
      msgChar = 8'h00;
   end
   // one-cycle request: 0 write, 1 code, 2 key, else message;
   // released data lines show the inverse so stale values never match
   task send(input int kind, input logic [7:0] val);
      @(negedge sys_clk);
      case (kind)
         0: progWrReq = 1'b1;
         1: begin
            fcAssignReq = 1'b1;
            fcAssignCode = val;
         end
         2: begin
            keyPress = 1'b1;
            keyIndex = val[4:0];
         end
         default: begin
            msgValid = 1'b1;
            msgChar = val;
         end
      endcase
      @(negedge sys_clk);
      {progWrReq, fcAssignReq, keyPress, msgValid} = 4'h0;
      fcAssignCode = ~fcAssignCode;
      keyIndex = ~keyIndex;
      msgChar = ~msgChar;
   endtask : send
endmodule : bscd_console_model
`default_nettype wire

// File: verif/test_board_strap_config_decoder.sv
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module test_board_strap_config_decoder;
   logic        sys_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1;
   logic [7:0]  swPins = 8'h00;
   logic        expBoardPresent = 1'b0, termKeyMapSel = 1'b0;
   logic [15:0] userSerBaud = 16'h0000, hostIoAddr = 16'h0000;
   logic [3:0]  userSerData = 4'h0, userSerStop = 4'h0;
   logic [1:0]  userSerParity = 2'h0;
   logic        progWrReq, fcAssignReq, keyPress, msgValid;
   logic [7:0]  fcAssignCode, msgChar, fcActive, consoleMsgChar;
   logic [4:0]  keyIndex;
   logic        cfgValid, progWrAccept, progWrReject, eepCopyStart;
   logic        langEnglish, fcAssignAccept, fcAssignReject, ioHit;
   logic        serUseExpPort, serOwnPortEn, termMode, consoleMsgValid;
   logic [15:0] serBaud, ioBase;
   logic [3:0]  serStartBits, serDataBits, serStopBits;
   logic [1:0]  serParity;
   logic [31:0] auxKeyBits, sw, usr, aux, code, base;
   int          failures = 0, checkCount = 0, cycles = 0;
   int          seed = 32'hdc88_a075, n, d;
   int          d_offs[4] = '{-1, 0, 4, 5}; // probe offsets around base
   bscd_top dut (.sys_clk, .arst_n, .clkEn, .swPins, .expBoardPresent,
      .progWrReq, .fcAssignReq, .fcAssignCode, .userSerBaud, .userSerData,
      .userSerStop, .userSerParity, .termKeyMapSel, .keyPress, .keyIndex,
      .msgValid, .msgChar, .hostIoAddr, .cfgValid, .progWrAccept,
      .progWrReject, .eepCopyStart, .langEnglish, .fcAssignAccept,
      .fcAssignReject, .fcActive, .serBaud, .serStartBits, .serDataBits,
      .serStopBits, .serParity, .serUseExpPort, .serOwnPortEn, .termMode,
      .auxKeyBits, .consoleMsgValid, .consoleMsgChar, .ioBase, .ioHit);
   bscd_console_model console (.sys_clk, .progWrReq, .fcAssignReq,
      .fcAssignCode, .keyPress, .keyIndex, .msgValid, .msgChar);
   always #2.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////
   // compare one result, four-state
   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string short_message_instruction);
      checkCount++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, short_message_instruction);
      end
   endtask : check
   // closing report
   task give_verdict;
      $display("checks %0d failures %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // hang guard: whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         give_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // each pass: random straps, reset, latch, then requests and probes
   initial begin
      for (int t = 0; t < 8; t++) begin
         sw = $random(seed);
         sw[7:6] = t[1:0];
         usr = $random(seed);
         // fields placed where the expectations below look for them
         termKeyMapSel = usr[26];
         userSerParity = usr[25:24];
         userSerStop = usr[19:16];
         userSerData = usr[31:28];
         userSerBaud = usr[15:0];
         expBoardPresent = usr[27];
         swPins = sw[7:0];
         arst_n = 1'b0;
         repeat (5) @(negedge sys_clk);
         arst_n = 1'b1;
         n = 0;
         while (cfgValid !== 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
         end
         check(cfgValid, 1, "latched");
         check(eepCopyStart, sw[1], "eeprom copy");
         swPins = ~sw[7:0];
         repeat (2) @(negedge sys_clk);
         // latched values must ignore the flipped switches
         check(langEnglish, sw[2], "language");
         check(termMode, sw[5], "terminal mode");
         check(serBaud, sw[4] ? 9600 : usr[15:0], "baud");
         check(serDataBits, sw[4] ? 7 : usr[31:28], "data");
         check(serStopBits, sw[4] ? 2 : usr[19:16], "stop");
         check(serParity, sw[4] ? 1 : usr[25:24], "parity");
         check(serStartBits, 1, "start");
         check(serUseExpPort, usr[27], "exp port");
         check(serOwnPortEn, !usr[27], "own port");
         console.send(0, 8'h00);
         check(progWrAccept, !sw[0], "write accept");
         check(progWrReject, sw[0], "write reject");
         code = $random(seed);
         console.send(1, code[7:0]);
         check(fcAssignAccept, sw[3], "code accept");
         check(fcAssignReject, !sw[3], "code reject");
         check(fcActive, sw[3] ? code[7:0] : 0, "code");
         aux = 0;
         for (int j = 0; j < 2; j++) begin
            code = $random(seed);
            console.send(2, code[7:0]);
            if (sw[5] && usr[26])
               aux[code[4:0]] = 1'b1;
            check(auxKeyBits, aux, "key bits");
            console.send(3, code[15:8]);
            d = sw[5] && !usr[26];
            check(consoleMsgValid, d, "message");
            if (d)
               check(consoleMsgChar, code[15:8], "text");
         end
         // window edges: one below, first, last, one past
         base = 32'h0000_03A0 - 32'h0000_0010 * sw[7:6];
         foreach (d_offs[k]) begin
            hostIoAddr = 16'(base + d_offs[k]);
            repeat (2) @(negedge sys_clk);
            check(ioBase, base, "base");
            check(ioHit, d_offs[k] >= 0 && d_offs[k] < 5, "hit");
         end
         // frozen clock enable: a key press must leave no trace
         clkEn = 1'b0;
         console.send(2, 8'h1F);
         check(auxKeyBits, aux, "frozen keys");
         clkEn = 1'b1;
         $display("test %0d done", t);
      end
      give_verdict;
   end
endmodule : test_board_strap_config_decoder
`default_nettype wire
